// [rtl/sar_adc_params.svh]
// Constants for the converter control block
`ifndef SAR_ADC_PARAMS_SVH
`define SAR_ADC_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define STEP_TIME_NS 1600
`define STEP_CYCLES ((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_FALL_MIN_NS 300
`define BUSY_FALL_CYCLES ((`BUSY_FALL_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESULT_BITS 12
`define SHORT_BITS 8
`define SHORT_FILL 4'h8
`endif

// [rtl/sar_adc_pkg.sv]
// Types for the converter control block
package sar_adc_pkg;
   typedef struct packed {
      logic chip_enable;
      logic chip_select_n;
      logic read_convert;
      logic bus_width_select;
      logic byte_length_select;
   } ctrl_t;
   typedef enum logic [2:0] {
      IDLE = 3'b001,
      CONV = 3'b010,
      HOLD = 3'b100
   } conv_state_t;
endpackage

// [rtl/sar_adc_host_control.sv]
// Control and output logic of a 12-bit successive-approximation converter
//
// Overview of operation
// - Start when chip enable high, chip select low, read_convert low; last one triggers.
// - Latch byte_length_select at start: low means 12 bits, high means 8 bits.
// - After 8-bit conversion, low three bits read zero and data_bit3 reads one.
// - Only byte_length_select is latched; other controls act at present level.
// - conversion_busy high exactly while a conversion runs, low otherwise.
// - Data outputs float while conversion_busy is high.
// - Start requests during busy are ignored, no reset or restart.
// - Drive data only with read_convert high, not busy, enabled, selected.
// - bus_width_select high drives all 12 lines, ignoring byte_length_select.
// - Byte mode with byte_length_select low enables only the 8 top bits.
// - Byte mode with it high: top 4 off, bits 4..7 low, low 4 on.
// - Byte switch releases one byte before enabling the other.
// - Busy falls 300 to 1200 ns after new data becomes valid.
// - One bit decision per step, 1.6 us interval by default.
`timescale 1ns/1ps
`include "sar_adc_params.svh"
module sar_adc_host_control #(
   parameter int STEP_CYCLES = `STEP_CYCLES,
   parameter int BUSY_FALL_CYCLES = `BUSY_FALL_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input sar_adc_pkg::ctrl_t ctrl,
   input wire logic comparator_high,
   output logic conversion_busy,
   output logic [11:0] data_out,
   output logic [11:0] data_oe_n
);
   import sar_adc_pkg::*;

   // ****************************************
   // Local constants
   // ****************************************
   // Index of the first bit decided, and of the last one in a short run
   localparam logic [3:0] FIRST_BIT = 4'(`RESULT_BITS - 1);
   localparam logic [3:0] SHORT_LAST_BIT = 4'(`RESULT_BITS - `SHORT_BITS);
   // Nibble enable patterns: [2] top, [1] middle, [0] low
   localparam logic [2:0] GRP_NONE = 3'b000;
   localparam logic [2:0] GRP_WORD = 3'b111;
   localparam logic [2:0] GRP_TOP = 3'b110;
   localparam logic [2:0] GRP_LOW = 3'b011;

   // ****************************************
   // Conversion sequencer
   // ****************************************
   conv_state_t state_r, state_nxt;
   logic [15:0] div_r, div_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic short_r, short_nxt;
   logic [11:0] trial_r, trial_nxt;
   logic [11:0] result_r, result_nxt;
   logic start_req;
   logic step_done;
   logic hold_done;

   // ****************************************
   // Start decode
   // ****************************************
   // Level decode, so whichever input arrives last fires the start
   // No edge detector: a start held through reset cannot be missed
   assign start_req = ctrl.chip_enable & ~ctrl.chip_select_n & ~ctrl.read_convert;

   // Step boundary from the divider; one bit is decided per step
   assign step_done = (div_r == 16'(STEP_CYCLES - 1));
   // Counter reused from the step divider to save a register
   assign hold_done = (div_r == 16'(BUSY_FALL_CYCLES - 1));

   // ****************************************
   // Sequencer next state
   // ****************************************
   // Divider, bit index and trial word move together, so one process
   always_comb begin
      state_nxt = state_r;
      div_nxt = div_r;
      bit_nxt = bit_r;
      short_nxt = short_r;
      trial_nxt = trial_r;
      result_nxt = result_r;
      case (state_r)
         IDLE: begin
            // A request still held on return to idle starts the next conversion at once
            if (start_req) begin
               state_nxt = CONV;
               // Short flag is the only control latched; the others act live
               short_nxt = ctrl.byte_length_select;
               bit_nxt = FIRST_BIT;
               trial_nxt = 12'h800;
               div_nxt = 16'h0000;
            end
         end
         CONV: begin
            // New starts are not looked at here
            // Comparator is only read on the last cycle of a step, once settled
            if (step_done) begin
               div_nxt = 16'h0000;
               if (!comparator_high) begin
                  trial_nxt[bit_r] = 1'b0;
               end
               if (bit_r != 4'h0) begin
                  trial_nxt[bit_r - 4'h1] = 1'b1;
               end
               if ((bit_r == 4'h0) || (short_r && bit_r == SHORT_LAST_BIT)) begin
                  result_nxt = trial_nxt;
                  // Short run: low nibble reads a trailing one then zeros
                  if (short_r) begin
                     result_nxt[3:0] = `SHORT_FILL;
                  end
                  state_nxt = HOLD;
               end else begin
                  bit_nxt = bit_r - 4'h1;
               end
            end else begin
               div_nxt = div_r + 16'h0001;
            end
         end
         HOLD: begin
            // Data valid before busy drops
            // Result already written, so the bus sees new data first
            if (hold_done) begin
               div_nxt = 16'h0000;
               state_nxt = IDLE;
            end else begin
               div_nxt = div_r + 16'h0001;
            end
         end
         // Illegal code falls back to idle rather than lock up
         default: state_nxt = IDLE;
      endcase
   end

   // ****************************************
   // Sequencer registers
   // ****************************************
   // Result stays zero until the first conversion completes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= IDLE;
         div_r <= 16'h0000;
         bit_r <= 4'h0;
         short_r <= 1'b0;
         trial_r <= 12'h000;
         result_r <= 12'h000;
      end else begin
         state_r <= state_nxt;
         div_r <= div_nxt;
         bit_r <= bit_nxt;
         short_r <= short_nxt;
         trial_r <= trial_nxt;
         result_r <= result_nxt;
      end
   end

   // ****************************************
   // Output drivers
   // ****************************************
   logic busy_nxt;
   logic read_en;
   logic [11:0] oe_n_nxt, out_nxt;
   logic [2:0] grp_want;
   logic [2:0] grp_r, grp_nxt;

   assign busy_nxt = (state_nxt != IDLE);
   // Next busy value, so drivers let go at the very edge busy rises
   assign read_en = ctrl.read_convert & ~busy_nxt & ctrl.chip_enable & ~ctrl.chip_select_n;

   // ****************************************
   // Output next values
   // ****************************************
   // Groups: [2] top nibble, [1] middle nibble, [0] low nibble
   always_comb begin
      grp_want = GRP_NONE;
      out_nxt = result_r;
      if (read_en) begin
         if (ctrl.bus_width_select) begin
            grp_want = GRP_WORD;
         end else if (!ctrl.byte_length_select) begin
            grp_want = GRP_TOP;
         end else begin
            grp_want = GRP_LOW;
            // Middle nibble forced low keeps the second byte right-justified
            out_nxt[7:4] = 4'h0;
            out_nxt[3:0] = result_r[3:0];
         end
      end
      // A change of byte first passes through all-off for one cycle
      // Cost: one dead cycle on each byte change
      if (((grp_r & ~grp_want) != GRP_NONE) && ((grp_want & ~grp_r) != GRP_NONE)) begin
         grp_nxt = GRP_NONE;
      end else begin
         grp_nxt = grp_want;
      end
      oe_n_nxt = ~{{4{grp_nxt[2]}}, {4{grp_nxt[1]}}, {4{grp_nxt[0]}}};
   end

   // ****************************************
   // Output registers
   // ****************************************
   // Every pin leaves a flip-flop, so no decode glitch reaches the bus
   // grp_r remembers which drivers are on now
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         grp_r <= GRP_NONE;
         conversion_busy <= 1'b0;
         data_out <= 12'h000;
         data_oe_n <= 12'hFFF;
      end else begin
         grp_r <= grp_nxt;
         conversion_busy <= busy_nxt;
         data_out <= out_nxt;
         data_oe_n <= oe_n_nxt;
      end
   end
endmodule

// [tb/sar_adc_host_control_props.sv]
// Port checks for the converter control block
`timescale 1ns/1ps
module sar_adc_host_control_props #(
   parameter int STEP_CYCLES = 4,
   parameter int BUSY_FALL_CYCLES = 2
) (
   input wire logic clk,
   input wire logic nrst,
   input sar_adc_pkg::ctrl_t ctrl,
   input wire logic conversion_busy,
   input wire logic [11:0] data_out,
   input wire logic [11:0] data_oe_n
);
   import sar_adc_pkg::*;
   logic rd, rd_sel;
   int bcnt_r;
   assign rd = ctrl.read_convert && ctrl.chip_enable && !ctrl.chip_select_n && !conversion_busy;
   // Drivers may open at the edge busy drops, so only pin qualifiers gate here
   assign rd_sel = ctrl.read_convert && ctrl.chip_enable && !ctrl.chip_select_n;
   // Busy cycles seen so far, cleared while idle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) bcnt_r <= 0;
      else bcnt_r <= conversion_busy ? bcnt_r + 1 : 0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_start; !conversion_busy && ctrl.chip_enable && !ctrl.chip_select_n && !ctrl.read_convert
      |=> conversion_busy; endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_len; $fell(conversion_busy) |-> bcnt_r == 12 * STEP_CYCLES + BUSY_FALL_CYCLES
      || bcnt_r == 8 * STEP_CYCLES + BUSY_FALL_CYCLES; endproperty
   a_len: assert property (p_len) else $error("busy length wrong");
   property p_float; conversion_busy |-> data_oe_n == 12'hFFF; endproperty
   a_float: assert property (p_float) else $error("driven while busy");
   property p_gate; !rd_sel |=> data_oe_n == 12'hFFF; endproperty
   a_gate: assert property (p_gate) else $error("driven without read");
   property p_wide; (rd && ctrl.bus_width_select) [*2] |=> data_oe_n == 12'h000; endproperty
   a_wide: assert property (p_wide) else $error("word read not 12 lines");
   property p_top; (rd && !ctrl.bus_width_select && !ctrl.byte_length_select) [*2] |=> data_oe_n == 12'h00F;
   endproperty
   a_top: assert property (p_top) else $error("top byte enables wrong");
   property p_low; (rd && !ctrl.bus_width_select && ctrl.byte_length_select) [*2]
      |=> data_oe_n == 12'hF00 && data_out[7:4] == 4'h0; endproperty
   a_low: assert property (p_low) else $error("low byte wrong");
   property p_bbm; (data_oe_n == 12'h00F |=> data_oe_n != 12'hF00)
      and (data_oe_n == 12'hF00 |=> data_oe_n != 12'h00F); endproperty
   a_bbm: assert property (p_bbm) else $error("bytes overlap");
endmodule
bind sar_adc_host_control sar_adc_host_control_props #(.STEP_CYCLES(STEP_CYCLES),
   .BUSY_FALL_CYCLES(BUSY_FALL_CYCLES)) u_props (.clk(clk), .nrst(nrst), .ctrl(ctrl),
   .conversion_busy(conversion_busy), .data_out(data_out), .data_oe_n(data_oe_n));

// [tb/adc_comparator_model.sv]
// Comparator stand-in: answers each step with one bit of a set code
`timescale 1ns/1ps
module adc_comparator_model #(
   parameter int STEP_CYCLES = 4
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic conversion_busy,
   input wire logic [11:0] code,
   output logic comparator_high
);
   int cnt_r;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) cnt_r <= 0;
      else cnt_r <= conversion_busy ? cnt_r + 1 : 0;
   end
   // Past twelve steps of busy time the answer toggles, so nothing may rely on it
   assign comparator_high = (cnt_r < 12 * STEP_CYCLES) ? code[11 - cnt_r / STEP_CYCLES] : cnt_r[0];
endmodule

// [tb/sar_adc_host_control_test.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module sar_adc_host_control_test;
   import sar_adc_pkg::*;
   localparam int S = 4;
   logic clk, nrst, comparator_high, conversion_busy;
   ctrl_t ctrl;
   logic [11:0] code, data_out, data_oe_n;
   int error_cnt, checked;
   sar_adc_host_control #(.STEP_CYCLES(S), .BUSY_FALL_CYCLES(2)) i_dut (.clk(clk), .nrst(nrst), .ctrl(ctrl),
      .comparator_high(comparator_high), .conversion_busy(conversion_busy), .data_out(data_out),
      .data_oe_n(data_oe_n));
   adc_comparator_model #(.STEP_CYCLES(S)) i_cmp (.clk(clk), .nrst(nrst), .conversion_busy(conversion_busy),
      .code(code), .comparator_high(comparator_high));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic stop_test();
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Start with all three inputs together, or the other two set up first; pulse again mid-run
   task automatic conv(input logic bls, input logic [11:0] c, input int n);
      int k;
      @(posedge clk);
      code <= c;
      if (bls) begin
         ctrl <= '{1'b1, 1'b0, 1'b1, 1'b1, bls};
         repeat (5) @(posedge clk);
      end
      ctrl <= '{1'b1, 1'b0, 1'b0, 1'b1, bls};
      @(posedge clk);
      #1;
      for (k = 0; k < 200 && conversion_busy; k++) begin
         if (k == 5) chk("oe_busy", 12'hFFF, data_oe_n);
         @(posedge clk);
         ctrl.read_convert <= !(k < 3 || (k >= 18 && k < 23));
         #1;
      end
      chk("busy_len", 12'(n * S + 2), 12'(k));
      if (k == 200) stop_test();
   endtask
   task automatic rd(input logic bw, input logic bls, input logic [11:0] oe, input logic [11:0] d);
      @(posedge clk);
      ctrl <= '{1'b1, 1'b0, 1'b1, bw, bls};
      repeat (3) @(posedge clk);
      #1;
      chk("oe", oe, data_oe_n);
      chk("data", d, data_out & ~data_oe_n);
   endtask
   initial begin
      ctrl = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      code = 12'h000;
      nrst = 1'b0;
      error_cnt = 0;
      checked = 0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      conv(1'b0, 12'hA5C, 12);
      rd(1'b1, 1'b0, 12'h000, 12'hA5C);
      rd(1'b0, 1'b0, 12'h00F, 12'hA50);
      rd(1'b0, 1'b1, 12'hF00, 12'h00C);
      conv(1'b1, 12'h3C7, 8);
      rd(1'b1, 1'b1, 12'h000, 12'h3C8);
      rd(1'b0, 1'b1, 12'hF00, 12'h008);
      rd(1'b0, 1'b0, 12'h00F, 12'h3C0);
      // Disabled part: no start and no drivers
      @(posedge clk);
      ctrl <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      repeat (3) @(posedge clk);
      #1;
      chk("busy_off", 12'h000, {11'h000, conversion_busy});
      chk("oe_off", 12'hFFF, data_oe_n);
      stop_test();
   end
endmodule
